// ### rtl/two_level_irq_controller.sv
// Fourteen-source two-level interrupt controller with APB register access
`timescale 1ns/1ps
// How it works
// - Each source has its own enable bit
// - Master gate bit blocks all interrupt requests to the core
// - Standard enable bits for six sources
// - Second enable register gates port-1 lines
// - One priority bit per source, two levels
// - Second priority register for port-1 lines
// - Port-1 lines level sensitive, wake power-down
// - Polarity register selects active level
// - Request flags set by hardware, software-cleared
// - Fixed vector per source
// - Fixed tie-break order within a level
// - Port-1 pins 0-7 carry lines 2-9
// - Interrupt offered to the core ends idle mode
// - Reset clears all controller registers except the pin synchronizers, which load ones
module two_level_irq_controller
(
	input  wire logic                                 sys_clk,
	input  wire logic                                 arst_n,
	// APB slave
	input  wire logic                                 psel,
	input  wire logic                                 penable,
	input  wire logic                                 pwrite,
	input  wire logic [irq_ctrl_pkg::ADDR_W-1:0]      paddr,
	input  wire logic [irq_ctrl_pkg::DATA_W-1:0]      pwdata,
	output logic [irq_ctrl_pkg::DATA_W-1:0]           prdata_r,
	output logic                                      pready_r,
	output logic                                      pslverr_r,
	// Standard sources, flags from on-chip logic
	input  wire logic                                 pin0Request,
	input  wire logic                                 pin1Request,
	input  wire logic                                 t0OverflowFlag,
	input  wire logic                                 t1OverflowFlag,
	input  wire logic                                 t2OverflowFlag,
	input  wire logic                                 t2ExternalFlag,
	input  wire logic                                 uartRxFlag,
	input  wire logic                                 uartTxFlag,
	// Port-1 pins, asynchronous
	input  wire logic [irq_ctrl_pkg::NUM_LINE-1:0]    port1Pin,
	// Processor core
	input  wire logic                                 irqAck,
	input  wire logic                                 irqReturn,
	input  wire logic                                 idleMode,
	input  wire logic                                 powerDown,
	output logic                                      irqReq_r,
	output irq_ctrl_pkg::vector_type                  irqVector_r,
	output logic                                      irqLevelHigh_r,
	output logic                                      idleWake_r,
	output logic                                      powerDownWake_r,
	output logic                                      irqOut_r
);
	import irq_ctrl_pkg::*;

	// ****************************************
	// Register bus
	// ****************************************
	apb_state_type        apbState_r;
	logic [IDX_W-1:0]     regIdx;
	logic                 mapped;
	logic                 wrStrobe;
	logic [7:0]           wrByte;
	logic [7:0]           rdByte;
	logic [7:0]           stdGate_r;
	logic [7:0]           stdPrio_r;
	logic [7:0]           polarity_r;
	logic [7:0]           linePrio_r;
	logic [7:0]           lineGate_r;
	logic [7:0]           lineReq_r;
	logic [7:0]           lineReq_nxt;
	logic [EVT_W-1:0]     evtStatus_r;
	logic [EVT_W-1:0]     evtStatus_nxt;
	logic [EVT_W-1:0]     evtEnable_r;
	logic [EVT_W-1:0]     evtSet;

	assign regIdx   = paddr[IDX_LSB +: IDX_W];
	assign wrByte   = pwdata[7:0];
	// A write lands only at the completing edge of the access phase
	assign wrStrobe = psel && penable && pready_r && pwrite && !pslverr_r;

	always_comb
	begin
		mapped = 1'b1;
		rdByte = 8'h00;
		unique case (regIdx)
			IDX_STD_GATE:   rdByte = stdGate_r;
			IDX_STD_PRIO:   rdByte = stdPrio_r;
			IDX_POLARITY:   rdByte = polarity_r;
			IDX_LINE_PRIO:  rdByte = linePrio_r;
			IDX_LINE_GATE:  rdByte = lineGate_r;
			IDX_LINE_REQ:   rdByte = lineReq_r;
			IDX_EVT_STATUS: rdByte = {4'h0, evtStatus_r};
			IDX_EVT_CLEAR:  rdByte = 8'h00;
			IDX_EVT_ENABLE: rdByte = {4'h0, evtEnable_r};
			default:        mapped = 1'b0;
		endcase
	end

	// One wait state: pready rises in the second access cycle
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			apbState_r <= APB_IDLE;
			pready_r   <= 1'b0;
			pslverr_r  <= 1'b0;
			prdata_r   <= '0;
		end
		else
		begin
			unique case (apbState_r)
				APB_IDLE:
				begin
					pready_r  <= 1'b0;
					pslverr_r <= 1'b0;
					if (psel && penable)
					begin
						apbState_r <= APB_ANSWER;
						pready_r   <= 1'b1;
						pslverr_r  <= !mapped;
						prdata_r   <= (!pwrite && mapped) ? {24'h000000, rdByte} : '0;
					end
				end
				APB_ANSWER:
				begin
					apbState_r <= APB_IDLE;
					pready_r   <= 1'b0;
					pslverr_r  <= 1'b0;
				end
				default:
				begin
					apbState_r <= APB_IDLE;
					pready_r   <= 1'b0;
					pslverr_r  <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			stdGate_r   <= REG_RESET;
			stdPrio_r   <= REG_RESET;
			polarity_r  <= REG_RESET;
			linePrio_r  <= REG_RESET;
			lineGate_r  <= REG_RESET;
			evtEnable_r <= EVT_RESET;
		end
		else if (wrStrobe)
		begin
			if (regIdx == IDX_STD_GATE)
				stdGate_r <= wrByte & STD_GATE_MASK;
			if (regIdx == IDX_STD_PRIO)
				stdPrio_r <= wrByte & STD_PRIO_MASK;
			if (regIdx == IDX_POLARITY)
				polarity_r <= wrByte;
			if (regIdx == IDX_LINE_PRIO)
				linePrio_r <= wrByte;
			if (regIdx == IDX_LINE_GATE)
				lineGate_r <= wrByte;
			if (regIdx == IDX_EVT_ENABLE)
				evtEnable_r <= wrByte[EVT_W-1:0];
		end
	end

	// ****************************************
	// Port-1 lines and request flags
	// ****************************************
	logic [NUM_LINE-1:0] lineMeta_r;
	logic [NUM_LINE-1:0] lineSync_r;
	logic [NUM_LINE-1:0] lineActive;

	// Pin k feeds line k+2 at bit k; reset to the pulled-up idle level, no false request
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			lineMeta_r <= '1;
			lineSync_r <= '1;
		end
		else
		begin
			lineMeta_r <= port1Pin;
			lineSync_r <= lineMeta_r;
		end
	end

	// Level sensitive: polarity 1 means active high
	assign lineActive = ~(lineSync_r ^ polarity_r);

	// Hardware only sets; a write replaces the value but a set in the same cycle wins
	always_comb
	begin
		lineReq_nxt = lineReq_r;
		if (wrStrobe && regIdx == IDX_LINE_REQ)
			lineReq_nxt = wrByte;
		lineReq_nxt = lineReq_nxt | lineActive;
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			lineReq_r <= REG_RESET;
		else
			lineReq_r <= lineReq_nxt;
	end

	// ****************************************
	// Source collection and arbitration
	// ****************************************
	logic [NUM_SRC-1:0]   pending;
	logic [NUM_SRC-1:0]   prioHigh;
	logic [7:0]           lineGated;
	logic                 winValid_r;
	logic                 winHigh_r;
	logic [SRC_IDX_W-1:0] winIdx_r;

	// A flag left set keeps the line pending after the routine returns
	assign lineGated = lineReq_r & lineGate_r;

	always_comb
	begin
		pending = '0;
		prioHigh = '0;
		pending[ORD_PIN0] = pin0Request && stdGate_r[BIT_PIN0];
		pending[ORD_T0]   = t0OverflowFlag && stdGate_r[BIT_T0];
		pending[ORD_PIN1] = pin1Request && stdGate_r[BIT_PIN1];
		pending[ORD_T1]   = t1OverflowFlag && stdGate_r[BIT_T1];
		pending[ORD_UART] = (uartRxFlag || uartTxFlag) && stdGate_r[BIT_UART];
		pending[ORD_T2]   = (t2OverflowFlag || t2ExternalFlag) && stdGate_r[BIT_T2];
		pending[ORD_L2]   = lineGated[0];
		pending[ORD_L3]   = lineGated[1];
		pending[ORD_L4]   = lineGated[2];
		pending[ORD_L5]   = lineGated[3];
		pending[ORD_L6]   = lineGated[4];
		pending[ORD_L7]   = lineGated[5];
		pending[ORD_L8]   = lineGated[6];
		pending[ORD_L9]   = lineGated[7];
		prioHigh[ORD_PIN0] = stdPrio_r[BIT_PIN0];
		prioHigh[ORD_T0]   = stdPrio_r[BIT_T0];
		prioHigh[ORD_PIN1] = stdPrio_r[BIT_PIN1];
		prioHigh[ORD_T1]   = stdPrio_r[BIT_T1];
		prioHigh[ORD_UART] = stdPrio_r[BIT_UART];
		prioHigh[ORD_T2]   = stdPrio_r[BIT_T2];
		prioHigh[ORD_L2]   = linePrio_r[0];
		prioHigh[ORD_L3]   = linePrio_r[1];
		prioHigh[ORD_L4]   = linePrio_r[2];
		prioHigh[ORD_L5]   = linePrio_r[3];
		prioHigh[ORD_L6]   = linePrio_r[4];
		prioHigh[ORD_L7]   = linePrio_r[5];
		prioHigh[ORD_L8]   = linePrio_r[6];
		prioHigh[ORD_L9]   = linePrio_r[7];
	end

	irq_arbiter arbiter
	(
		.sys_clk    (sys_clk),
		.arst_n     (arst_n),
		.pending    (pending),
		.prioHigh   (prioHigh),
		.winValid_r (winValid_r),
		.winHigh_r  (winHigh_r),
		.winIdx_r   (winIdx_r)
	);

	// ****************************************
	// In-service tracking and core request
	// ****************************************
	logic inSvcHigh_r;
	logic inSvcLow_r;
	logic inSvcHigh_nxt;
	logic inSvcLow_nxt;
	logic eligible;

	always_comb
	begin
		inSvcHigh_nxt = inSvcHigh_r;
		inSvcLow_nxt  = inSvcLow_r;
		// Return ends the innermost routine, which is the high one if any
		if (irqReturn)
		begin
			if (inSvcHigh_r)
				inSvcHigh_nxt = 1'b0;
			else
				inSvcLow_nxt = 1'b0;
		end
		if (irqAck && irqReq_r)
		begin
			if (irqLevelHigh_r)
				inSvcHigh_nxt = 1'b1;
			else
				inSvcLow_nxt = 1'b1;
		end
	end

	// Same or lower level waits; high preempts only a low routine
	assign eligible = winValid_r && stdGate_r[BIT_MASTER] && !inSvcHigh_nxt
		&& (winHigh_r || !inSvcLow_nxt);

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			inSvcHigh_r    <= 1'b0;
			inSvcLow_r     <= 1'b0;
			irqReq_r       <= 1'b0;
			irqVector_r    <= '0;
			irqLevelHigh_r <= 1'b0;
		end
		else
		begin
			inSvcHigh_r <= inSvcHigh_nxt;
			inSvcLow_r  <= inSvcLow_nxt;
			// Dropped for one cycle after an ack so a stale winner is not offered twice
			irqReq_r    <= eligible && !irqAck;
			if (eligible && !irqAck)
			begin
				irqVector_r    <= vectorOf(winIdx_r);
				irqLevelHigh_r <= winHigh_r;
			end
		end
	end

	// ****************************************
	// Power management wake-ups
	// ****************************************
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			idleWake_r      <= 1'b0;
			powerDownWake_r <= 1'b0;
		end
		else
		begin
			idleWake_r      <= idleMode && eligible;
			// Wake needs the line enabled only, not the master gate
			powerDownWake_r <= powerDown && |(lineActive & lineGate_r);
		end
	end

	// ****************************************
	// Event status and interrupt output
	// ****************************************
	assign evtSet = {|(lineActive & ~lineReq_r), powerDown && |(lineActive & lineGate_r),
		idleMode && eligible, irqAck && irqReq_r};

	// Set wins over a clear in the same cycle
	always_comb
	begin
		evtStatus_nxt = evtStatus_r;
		if (wrStrobe && regIdx == IDX_EVT_CLEAR)
			evtStatus_nxt = evtStatus_nxt & ~wrByte[EVT_W-1:0];
		evtStatus_nxt = evtStatus_nxt | evtSet;
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			evtStatus_r <= EVT_RESET;
			irqOut_r    <= 1'b0;
		end
		else
		begin
			evtStatus_r <= evtStatus_nxt;
			irqOut_r    <= |(evtStatus_nxt & evtEnable_r);
		end
	end

endmodule

// ### rtl/irq_ctrl_pkg.sv
// Constants, register map and vector table of the two-level interrupt controller
package irq_ctrl_pkg;

	// ****************************************
	// Bus and register map
	// ****************************************
	localparam int         ADDR_W         = 12;
	localparam int         DATA_W         = 32;
	localparam int         IDX_LSB        = 2;
	localparam int         IDX_W          = 8;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_STD_GATE   = 8'hA8;
	localparam logic [7:0] IDX_STD_PRIO   = 8'hB8;
	localparam logic [7:0] IDX_POLARITY   = 8'hE9;
	localparam logic [7:0] IDX_LINE_PRIO  = 8'hF8;
	localparam logic [7:0] IDX_LINE_GATE  = 8'hA9;
	localparam logic [7:0] IDX_LINE_REQ   = 8'hC0;
	localparam logic [7:0] IDX_EVT_STATUS = 8'hD0;
	localparam logic [7:0] IDX_EVT_CLEAR  = 8'hD1;
	localparam logic [7:0] IDX_EVT_ENABLE = 8'hD2;
	localparam logic [7:0] REG_RESET      = 8'h00;
	localparam logic [3:0] EVT_RESET      = 4'h0;

	// ****************************************
	// Field positions of the standard gate and priority registers
	// ****************************************
	localparam int BIT_PIN0   = 0;
	localparam int BIT_T0     = 1;
	localparam int BIT_PIN1   = 2;
	localparam int BIT_T1     = 3;
	localparam int BIT_UART   = 4;
	localparam int BIT_T2     = 5;
	localparam int BIT_MASTER = 7;
	localparam logic [7:0] STD_GATE_MASK = 8'hBF;
	localparam logic [7:0] STD_PRIO_MASK = 8'h3F;

	// ****************************************
	// Event status bits
	// ****************************************
	localparam int EVT_W         = 4;
	localparam int EVT_TAKEN     = 0;
	localparam int EVT_IDLE_WAKE = 1;
	localparam int EVT_PD_WAKE   = 2;
	localparam int EVT_LINE_REQ  = 3;

	// ****************************************
	// Sources in tie-break order, index 0 served first
	// ****************************************
	localparam int NUM_SRC   = 14;
	localparam int SRC_IDX_W = 4;
	localparam int NUM_LINE  = 8;
	localparam int ORD_PIN0  = 0;
	localparam int ORD_UART  = 1;
	localparam int ORD_L5    = 2;
	localparam int ORD_T0    = 3;
	localparam int ORD_L6    = 4;
	localparam int ORD_PIN1  = 5;
	localparam int ORD_L2    = 6;
	localparam int ORD_L7    = 7;
	localparam int ORD_T1    = 8;
	localparam int ORD_T2    = 9;
	localparam int ORD_L3    = 10;
	localparam int ORD_L8    = 11;
	localparam int ORD_L4    = 12;
	localparam int ORD_L9    = 13;

	typedef logic [15:0] vector_type;

	typedef enum logic [1:0]
	{
		APB_IDLE   = 2'b00,
		APB_ANSWER = 2'b01
	} apb_state_type;

	function automatic vector_type vectorOf(input logic [SRC_IDX_W-1:0] idx);
		vector_type v;
		v = 16'h0000;
		case (idx)
			4'h0: v = 16'h0003;
			4'h1: v = 16'h0023;
			4'h2: v = 16'h0053;
			4'h3: v = 16'h000B;
			4'h4: v = 16'h005B;
			4'h5: v = 16'h0013;
			4'h6: v = 16'h003B;
			4'h7: v = 16'h0063;
			4'h8: v = 16'h001B;
			4'h9: v = 16'h002B;
			4'hA: v = 16'h0043;
			4'hB: v = 16'h006B;
			4'hC: v = 16'h004B;
			4'hD: v = 16'h0073;
			default: v = 16'h0000;
		endcase
		return v;
	endfunction

endpackage

// ### rtl/irq_arbiter.sv
// Registered two-level winner selection among pending sources
`timescale 1ns/1ps
module irq_arbiter
(
	input  wire logic                                 sys_clk,
	input  wire logic                                 arst_n,
	input  wire logic [irq_ctrl_pkg::NUM_SRC-1:0]     pending,
	input  wire logic [irq_ctrl_pkg::NUM_SRC-1:0]     prioHigh,
	output logic                                      winValid_r,
	output logic                                      winHigh_r,
	output logic [irq_ctrl_pkg::SRC_IDX_W-1:0]        winIdx_r
);
	import irq_ctrl_pkg::*;

	// Lowest set bit wins; bit order is the tie-break order
	function automatic logic [SRC_IDX_W-1:0] firstSet(input logic [NUM_SRC-1:0] vec);
		logic [SRC_IDX_W-1:0] idx;
		idx = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--)
		begin
			if (vec[i])
				idx = SRC_IDX_W'(i);
		end
		return idx;
	endfunction

	logic [NUM_SRC-1:0] highReq;

	assign highReq = pending & prioHigh;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			winValid_r <= 1'b0;
			winHigh_r  <= 1'b0;
			winIdx_r   <= '0;
		end
		else
		begin
			winValid_r <= |pending;
			winHigh_r  <= |highReq;
			// High level first, then fixed order within the level
			winIdx_r   <= (|highReq) ? firstSet(highReq) : firstSet(pending);
		end
	end

endmodule

// ### testbench/core_model.sv
// Processor core model that acknowledges presented interrupt requests
`timescale 1ns/1ps
module core_model
(
	input  wire logic       sys_clk,
	input  wire logic       arst_n,
	input  wire logic       irqReq,
	input  wire logic [3:0] ackDelay,
	output logic            irqAck
);
	// ****************************************
	// Acknowledge after a programmable wait, prompt or slow
	// ****************************************
	logic [3:0] waitCnt_r;
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			waitCnt_r <= 4'h0;
			irqAck    <= 1'b0;
		end
		else
		begin
			irqAck <= 1'b0;
			// One pulse per request: the request drops the cycle after the pulse lands
			if (!irqReq || irqAck)
				waitCnt_r <= 4'h0;
			else if (waitCnt_r == ackDelay)
				irqAck <= 1'b1;
			else
				waitCnt_r <= waitCnt_r + 4'h1;
		end
	end
endmodule

// ### testbench/irq_ctrl_sva.sv
// Port-level checker of the interrupt controller
`timescale 1ns/1ps
module irq_ctrl_sva
(
	input  wire logic                            sys_clk,
	input  wire logic                            arst_n,
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic [irq_ctrl_pkg::DATA_W-1:0] prdata_r,
	input  wire logic                            pready_r,
	input  wire logic                            pslverr_r,
	input  wire logic                            irqAck,
	input  wire logic                            idleMode,
	input  wire logic                            powerDown,
	input  wire logic                            irqReq_r,
	input  wire irq_ctrl_pkg::vector_type        irqVector_r,
	input  wire logic                            idleWake_r,
	input  wire logic                            powerDownWake_r
);
	import irq_ctrl_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// ****************************************
	// Bus answer, request hand-off, vectors and wake-ups
	// ****************************************
	sequence accessWait;
		psel && penable && !pready_r;
	endsequence
	sequence answerPulse;
		pready_r ##1 !pready_r;
	endsequence
	a_apb_answer: assert property (accessWait |=> answerPulse)
		else $error("bus answer missing or too long");
	a_err_with_ready: assert property (pslverr_r |-> pready_r && prdata_r == 32'h0)
		else $error("error without ready or with data");
	a_rdata_upper: assert property (pready_r |-> prdata_r[31:8] == 24'h000000)
		else $error("read data above low byte");
	a_ack_drops_req: assert property (irqReq_r && irqAck |=> !irqReq_r)
		else $error("request stays after acknowledge");
	a_vector_legal: assert property (irqReq_r |-> irqVector_r[2:0] == 3'h3
		&& irqVector_r <= 16'h0073 && irqVector_r != 16'h0033)
		else $error("illegal vector");
	a_idle_wake: assert property (idleWake_r |-> $past(idleMode) && (irqReq_r || $past(irqAck)))
		else $error("idle wake outside idle");
	a_pd_wake: assert property (powerDownWake_r |-> $past(powerDown))
		else $error("power-down wake outside power-down");
	a_req_stable: assert property (irqReq_r && !irqAck && !$past(irqAck) |=> irqReq_r)
		else $error("request withdrawn without acknowledge");
endmodule
bind two_level_irq_controller irq_ctrl_sva u_sva (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel),
	.penable(penable), .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
	.irqAck(irqAck), .idleMode(idleMode), .powerDown(powerDown), .irqReq_r(irqReq_r),
	.irqVector_r(irqVector_r), .idleWake_r(idleWake_r), .powerDownWake_r(powerDownWake_r));

// ### testbench/two_level_irq_controller_tb.sv
// Self-checking bench of the interrupt controller
`timescale 1ns/1ps
module two_level_irq_controller_tb;
	import irq_ctrl_pkg::*;
	logic sys_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata_r;
	logic pready_r, pslverr_r, irqAck, irqReturn = 1'b0, idleMode = 1'b0, powerDown = 1'b0;
	logic pin0, pin1, t0, t1, t2Ovf, t2Ext, uRx, uTx;
	logic [7:0] port1Pin = 8'hFF, lineFlags;
	logic [3:0] ackDelay = 4'h1;
	logic irqReq_r, irqLevelHigh_r, idleWake_r, powerDownWake_r, irqOut_r;
	vector_type irqVector_r;
	int failCount = 0, nChecks = 0, cycles = 0;
	initial {pin0, pin1, t0, t1, t2Ovf, t2Ext, uRx, uTx} = 8'h00;
	always #4 sys_clk = ~sys_clk;
	two_level_irq_controller dut (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r),
		.pready_r(pready_r), .pslverr_r(pslverr_r), .pin0Request(pin0), .pin1Request(pin1),
		.t0OverflowFlag(t0), .t1OverflowFlag(t1), .t2OverflowFlag(t2Ovf), .t2ExternalFlag(t2Ext),
		.uartRxFlag(uRx), .uartTxFlag(uTx), .port1Pin(port1Pin), .irqAck(irqAck),
		.irqReturn(irqReturn), .idleMode(idleMode), .powerDown(powerDown), .irqReq_r(irqReq_r),
		.irqVector_r(irqVector_r), .irqLevelHigh_r(irqLevelHigh_r), .idleWake_r(idleWake_r),
		.powerDownWake_r(powerDownWake_r), .irqOut_r(irqOut_r));
	core_model core (.sys_clk(sys_clk), .arst_n(arst_n), .irqReq(irqReq_r), .ackDelay(ackDelay),
		.irqAck(irqAck));
	// ****************************************
	// Shared tasks
	// ****************************************
	task giveVerdict;
		if (failCount == 0 && nChecks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge sys_clk)
	begin
		cycles++;
		// Whole run needs well under a thousand cycles; far above that means a hang
		if (cycles == 20000)
		begin
			failCount++;
			giveVerdict();
		end
	end
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		nChecks++;
		if (seen !== exp)
		begin
			failCount++;
			$display("BAD %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task apb(input logic isWr, input logic [7:0] idx, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= isWr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		// Only the bench timeout ends this wait
		do @(posedge sys_clk); while (pready_r !== 1'b1);
		rd = prdata_r;
		err = pslverr_r;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] rd;
		logic err;
		apb(1'b1, idx, {24'h0, d}, rd, err);
	endtask
	task rdChk(input logic [7:0] idx, input logic [7:0] exp, input logic expErr);
		logic [31:0] rd;
		logic err;
		apb(1'b0, idx, 32'h0, rd, err);
		chk("rdata", rd, {24'h0, exp});
		chk("pslverr", 32'(err), 32'(expErr));
	endtask
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task take(input logic [15:0] vec, input logic lvl);
		int n;
		n = 0;
		do @(posedge sys_clk); while (irqReq_r !== 1'b1 && ++n < 60);
		#1;
		chk("request", 32'(irqReq_r), 32'h1);
		chk("vector", 32'(irqVector_r), 32'(vec));
		chk("level", 32'(irqLevelHigh_r), 32'(lvl));
		n = 0;
		do @(posedge sys_clk); while (irqReq_r !== 1'b0 && ++n < 60);
	endtask
	task none(input int n);
		cyc(n);
		chk("no request", 32'(irqReq_r), 32'h0);
	endtask
	task ret;
		@(posedge sys_clk) irqReturn <= 1'b1;
		@(posedge sys_clk) irqReturn <= 1'b0;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task sRegisters;
		logic [7:0] idx [6] = '{IDX_STD_GATE, IDX_STD_PRIO, IDX_POLARITY, IDX_LINE_PRIO,
			IDX_LINE_GATE, IDX_LINE_REQ};
		logic [7:0] msk [6] = '{8'hBF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
		foreach (idx[i]) rdChk(idx[i], 8'h00, 1'b0);
		rdChk(IDX_EVT_ENABLE, 8'h00, 1'b0);
		foreach (idx[i])
		begin
			wr(idx[i], 8'hFF);
			rdChk(idx[i], msk[i], 1'b0);
			wr(idx[i], 8'h00);
		end
		rdChk(8'h00, 8'h00, 1'b1);
		rdChk(IDX_EVT_CLEAR, 8'h00, 1'b0);
	endtask
	task sGateEvents;
		wr(IDX_EVT_CLEAR, 8'h0F);
		wr(IDX_EVT_ENABLE, 8'h01);
		wr(IDX_STD_GATE, 8'h01);
		pin0 <= 1'b1;
		t0 <= 1'b1;
		none(8);
		wr(IDX_STD_GATE, 8'h81);
		take(16'h0003, 1'b0);
		pin0 <= 1'b0;
		cyc(3);
		chk("irq out", 32'(irqOut_r), 32'h1);
		rdChk(IDX_EVT_STATUS, 8'h01, 1'b0);
		ret();
		none(8);
		t0 <= 1'b0;
		wr(IDX_EVT_ENABLE, 8'h00);
		cyc(2);
		chk("irq masked", 32'(irqOut_r), 32'h0);
		wr(IDX_EVT_ENABLE, 8'h01);
		cyc(2);
		chk("irq unmasked", 32'(irqOut_r), 32'h1);
		wr(IDX_EVT_CLEAR, 8'h0F);
		cyc(2);
		chk("irq cleared", 32'(irqOut_r), 32'h0);
		rdChk(IDX_EVT_STATUS, 8'h00, 1'b0);
		wr(IDX_EVT_ENABLE, 8'h00);
	endtask
	task sPreempt;
		wr(IDX_STD_GATE, 8'h9A);
		wr(IDX_STD_PRIO, 8'h08);
		t0 <= 1'b1;
		take(16'h000B, 1'b0);
		t0 <= 1'b0;
		t1 <= 1'b1;
		take(16'h001B, 1'b1);
		t1 <= 1'b0;
		uTx <= 1'b1;
		none(8);
		ret();
		none(8);
		ret();
		take(16'h0023, 1'b0);
		uTx <= 1'b0;
		ret();
		wr(IDX_STD_GATE, 8'h00);
		wr(IDX_STD_PRIO, 8'h00);
	endtask
	task sWake;
		ackDelay <= 4'h8;
		idleMode <= 1'b1;
		wr(IDX_STD_GATE, 8'h81);
		pin0 <= 1'b1;
		cyc(4);
		chk("idle wake", 32'(idleWake_r), 32'h1);
		take(16'h0003, 1'b0);
		pin0 <= 1'b0;
		idleMode <= 1'b0;
		ret();
		wr(IDX_STD_GATE, 8'h00);
		ackDelay <= 4'h1;
		powerDown <= 1'b1;
		wr(IDX_LINE_GATE, 8'h01);
		port1Pin <= 8'hFE;
		cyc(6);
		chk("pd wake", 32'(powerDownWake_r), 32'h1);
		port1Pin <= 8'hFF;
		powerDown <= 1'b0;
		cyc(4);
		wr(IDX_LINE_REQ, 8'h00);
		wr(IDX_LINE_GATE, 8'h00);
	endtask
	task sTieOrder;
		logic [15:0] vec [14] = '{16'h0003, 16'h0023, 16'h0053, 16'h000B, 16'h005B, 16'h0013,
			16'h003B, 16'h0063, 16'h001B, 16'h002B, 16'h0043, 16'h006B, 16'h004B, 16'h0073};
		int lineOf [14] = '{0, 0, 5, 0, 6, 0, 2, 7, 0, 0, 3, 8, 4, 9};
		lineFlags = 8'hFF;
		wr(IDX_LINE_GATE, 8'hFF);
		wr(IDX_STD_GATE, 8'hBF);
		{pin0, pin1, t0, t1, t2Ext, uRx} <= 6'h3F;
		port1Pin <= 8'h00;
		for (int k = 0; k < 14; k++)
		begin
			take(vec[k], 1'b0);
			case (k)
				0: pin0 <= 1'b0;
				1: uRx <= 1'b0;
				3: t0 <= 1'b0;
				5: pin1 <= 1'b0;
				8: t1 <= 1'b0;
				9: t2Ext <= 1'b0;
				default:
				begin
					port1Pin[lineOf[k]-2] <= 1'b1;
					cyc(4);
					rdChk(IDX_LINE_REQ, lineFlags, 1'b0);
					lineFlags[lineOf[k]-2] = 1'b0;
					wr(IDX_LINE_REQ, lineFlags);
				end
			endcase
			ret();
		end
		wr(IDX_STD_GATE, 8'h00);
		wr(IDX_LINE_GATE, 8'h00);
	endtask
	task sFlagRepeat;
		wr(IDX_POLARITY, 8'h02);
		port1Pin <= 8'hFD;
		cyc(4);
		wr(IDX_LINE_REQ, 8'h00);
		wr(IDX_LINE_GATE, 8'h02);
		wr(IDX_STD_GATE, 8'h80);
		t2Ovf <= 1'b1;
		none(8);
		t2Ovf <= 1'b0;
		port1Pin <= 8'hFF;
		cyc(3);
		port1Pin <= 8'hFD;
		take(16'h0043, 1'b0);
		ret();
		take(16'h0043, 1'b0);
		wr(IDX_LINE_REQ, 8'h00);
		ret();
		none(8);
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		repeat (4) @(posedge sys_clk);
		arst_n <= 1'b1;
		sRegisters();
		sGateEvents();
		sPreempt();
		sWake();
		sTieOrder();
		sFlagRepeat();
		giveVerdict();
	end
endmodule
